/* src/power_state_sequencer_consts.vh */
// Purpose: Constants for the power state sequencer
// Assumes: 125 MHz system clock, 8-bit register port
// Notes:   Registers 0x0e and 0x0f hold the stop bit and watchdog flags
`ifndef POWER_STATE_SEQUENCER_CONSTS_VH
`define POWER_STATE_SEQUENCER_CONSTS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define ADDR_W              4
`define REG_CLOCK_STOP      4'he
`define REG_WD_FLAGS        4'hf
`define REG_CONFIG          4'h0
`define REG_STATUS          4'h1
`define REG_IRQ_STATUS      4'h2
`define REG_IRQ_MASK        4'h3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CK_STOP_BIT         4
`define WD_POR_BIT          7
`define WD_IRQ_EN_BIT       6
`define WD_RST_EN_BIT       1
`define CFG_ADC_BIT         0
`define CFG_PROT_BIT        1
`define CFG_TMR_BIT         2
`define CFG_BO_IRQ_BIT      3
`define PMM_LO              4
`define PMM_HI              5
`define EV_BO_RECOVER       0
`define EV_BO_TIMEOUT       1
`define EV_WAKE             2
`define EV_CHARGER          3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_BYTE            8'h00
`define RST_WD_FLAGS        8'h80
`define ONE_BYTE            8'h01

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS       8
`define BO_WINDOW_NS        2000000
`define WIN_W               20

`endif

/* src/power_state_sequencer.v */
// Purpose: Power-state controller: brown-out, CPU, analog, sleep, charger wait
// Assumes: Inputs synchronous to i_sys_clk; register port with one-cycle read data
// Notes:   Recovery window counted on system clock, shortened by parameter
//
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`include "power_state_sequencer_consts.vh"

module power_state_sequencer #(
  parameter BO_WINDOW_CYCLES = `BO_WINDOW_NS / `CLK_PERIOD_NS
) (
  input  wire                i_sys_clk,
  input  wire                i_resetn,
  input  wire [`ADDR_W-1:0]  i_addr,
  input  wire [7:0]          i_wdata,
  input  wire                i_wr,
  input  wire                i_rd,
  input  wire                i_supply_low,
  input  wire                i_stop_req,
  input  wire                i_adc_active,
  input  wire                i_prot_active,
  input  wire                i_interval_timer_active,
  input  wire                i_internal_irq,
  input  wire                i_ext_irq,
  input  wire                i_twowire_irq,
  input  wire                i_port0_wake,
  input  wire                i_port1_wake,
  input  wire                i_charger_sense_input,
  output reg  [7:0]          o_rdata,
  output reg                 o_cpu_run,
  output reg                 o_ip_hold,
  output reg                 o_instruction_oscillator_en,
  output reg                 o_analog_oscillator_en,
  output reg                 o_analog_domain_en,
  output reg                 o_brownout_irq,
  output reg                 o_irq,
  output reg  [4:0]          o_state
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [4:0] ST_BROWNOUT = 5'h01;
  localparam [4:0] ST_CPU      = 5'h02;
  localparam [4:0] ST_ANALOG   = 5'h04;
  localparam [4:0] ST_SLEEP    = 5'h08;
  localparam [4:0] ST_WAIT     = 5'h10;
  localparam [31:0]       WIN_LAST_FULL = BO_WINDOW_CYCLES - 1;
  localparam [`WIN_W-1:0] WIN_LAST      = WIN_LAST_FULL[`WIN_W-1:0];

  reg [4:0]          state;
  reg [4:0]          next_state;
  reg [7:0]          clock_stop_control;
  reg [7:0]          watchdog_and_reset_flags;
  reg [7:0]          config_reg;
  reg [7:0]          irq_status;
  reg [7:0]          irq_mask;
  reg [`WIN_W-1:0]   win_cnt;
  reg                was_fault;
  reg [7:0]          next_rdata;
  reg [3:0]          events;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // One address decoder shared by every write strobe and the status read-clear; the read data mux decodes on its own
  function reg_hit;
    input                strobe;
    input [`ADDR_W-1:0]  addr;
    input [`ADDR_W-1:0]  target;
    begin
      reg_hit = strobe && (addr == target);
    end
  endfunction

  function quiet_state;
    input [4:0] st;
    begin
      quiet_state = (st == ST_SLEEP) || (st == ST_WAIT);
    end
  endfunction

  function fault_entry;
    input [4:0] st;
    input [4:0] nst;
    begin
      fault_entry = (st == ST_CPU || st == ST_ANALOG) && (nst == ST_BROWNOUT);
    end
  endfunction

  // ----------------------------------------
  // Decode
  // ----------------------------------------

  wire watchdog_irq_enable    = watchdog_and_reset_flags[`WD_IRQ_EN_BIT];
  wire watchdog_reset_enable  = watchdog_and_reset_flags[`WD_RST_EN_BIT];
  wire [1:0] protector_monitor_mode = config_reg[`PMM_HI:`PMM_LO];
  wire interval_timer_config  = config_reg[`CFG_TMR_BIT];

  // Any analog user; sampled in the stop cycle itself
  wire analog_needed = i_adc_active | i_prot_active | i_interval_timer_active |
                       config_reg[`CFG_ADC_BIT] | config_reg[`CFG_PROT_BIT] |
                       interval_timer_config | watchdog_irq_enable |
                       watchdog_reset_enable;
  wire stop_cmd = i_stop_req |
                  (reg_hit(i_wr, i_addr, `REG_CLOCK_STOP) && i_wdata[`CK_STOP_BIT]);
  wire sleep_wake = i_twowire_irq | i_port0_wake | i_port1_wake |
                    i_charger_sense_input;
  wire win_done = (win_cnt == WIN_LAST);

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  always @* begin
    next_state = state;
    events     = 4'h0;
    case (state)
      ST_BROWNOUT: begin
        if (!i_supply_low) begin
          next_state = ST_CPU;
          if (was_fault) begin
            events[`EV_BO_RECOVER] = 1'b1;
          end
        end else if (was_fault && win_done) begin
          next_state = ST_WAIT;
          events[`EV_BO_TIMEOUT] = 1'b1;
        end
      end
      ST_CPU: begin
        if (i_supply_low) begin
          next_state = ST_BROWNOUT;
        end else if (stop_cmd) begin
          if (analog_needed) begin
            next_state = ST_ANALOG;
          end else begin
            next_state = ST_SLEEP;
          end
        end
      end
      ST_ANALOG: begin
        if (i_supply_low)
          next_state = ST_BROWNOUT;
        else if (i_ext_irq | i_internal_irq | sleep_wake) begin
          next_state = ST_CPU;
          events[`EV_WAKE] = 1'b1;
        end
      end
      ST_SLEEP: begin
        // Supply comparator not looked at here
        if (sleep_wake) begin
          next_state = ST_BROWNOUT;
          events[`EV_WAKE] = 1'b1;
        end
      end
      ST_WAIT: begin
        if (i_charger_sense_input) begin
          next_state = ST_BROWNOUT;
          events[`EV_CHARGER] = 1'b1;
        end
      end
      default: next_state = ST_BROWNOUT;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ST_BROWNOUT;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Recovery window
  // ----------------------------------------
  // Counts only while parked in brown-out; any move clears it
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      win_cnt <= {`WIN_W{1'b0}};
    end else if (state != ST_BROWNOUT || next_state != ST_BROWNOUT) begin
      win_cnt <= {`WIN_W{1'b0}};
    end else if (!win_done) begin
      win_cnt <= win_cnt + 1'b1;
    end
  end

  // Window only applies after a fault from CPU or analog
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      was_fault <= 1'b0;
    end else if (fault_entry(state, next_state)) begin
      was_fault <= 1'b1;
    end else if (state == ST_BROWNOUT && next_state != ST_BROWNOUT) begin
      was_fault <= 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      clock_stop_control <= `RST_BYTE;
    end else if (reg_hit(i_wr, i_addr, `REG_CLOCK_STOP)) begin
      // Stop bit self-clears; it acts through stop_cmd only
      clock_stop_control <= i_wdata & ~(`ONE_BYTE << `CK_STOP_BIT);
    end
  end

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      watchdog_and_reset_flags <= `RST_WD_FLAGS;
    end else if (reg_hit(i_wr, i_addr, `REG_WD_FLAGS)) begin
      watchdog_and_reset_flags <= i_wdata;
    end
  end

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      config_reg <= `RST_BYTE;
    end else if (reg_hit(i_wr, i_addr, `REG_CONFIG)) begin
      config_reg <= i_wdata;
    end
  end

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_mask <= `RST_BYTE;
    end else if (reg_hit(i_wr, i_addr, `REG_IRQ_MASK)) begin
      irq_mask <= i_wdata;
    end
  end

  // ----------------------------------------
  // Interrupt flags
  // ----------------------------------------
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_status <= `RST_BYTE;
    end else if (reg_hit(i_rd, i_addr, `REG_IRQ_STATUS)) begin
      // Set wins over read-clear
      irq_status <= {4'h0, events};
    end else begin
      irq_status <= irq_status | {4'h0, events};
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------

  always @* begin
    next_rdata = `RST_BYTE;
    if (i_addr == `REG_CLOCK_STOP)
      next_rdata = clock_stop_control;
    else if (i_addr == `REG_WD_FLAGS)
      next_rdata = watchdog_and_reset_flags;
    else if (i_addr == `REG_CONFIG)
      next_rdata = config_reg;
    else if (i_addr == `REG_STATUS)
      next_rdata = {3'h0, state};
    else if (i_addr == `REG_IRQ_STATUS)
      next_rdata = irq_status;
    else if (i_addr == `REG_IRQ_MASK)
      next_rdata = irq_mask;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Read data stand for one cycle only, zero otherwise
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= `RST_BYTE;
    end else begin
      o_rdata <= i_rd ? next_rdata : `RST_BYTE;
    end
  end

  // ----------------------------------------
  // Run and hold
  // ----------------------------------------
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cpu_run <= 1'b0;
    end else begin
      o_cpu_run <= (next_state == ST_CPU);
    end
  end

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ip_hold <= 1'b1;
    end else begin
      o_ip_hold <= (next_state == ST_BROWNOUT);
    end
  end

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_state <= ST_BROWNOUT;
    end else begin
      o_state <= next_state;
    end
  end

  // ----------------------------------------
  // Oscillators and domains
  // ----------------------------------------
  // Oscillator runs in CPU state, and reset also loads it on in brown-out: on after wake or reset, off on stop
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_instruction_oscillator_en <= 1'b1;
    end else begin
      o_instruction_oscillator_en <= (next_state == ST_CPU);
    end
  end

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_analog_oscillator_en <= 1'b0;
    end else begin
      o_analog_oscillator_en <= !quiet_state(next_state) &&
                                (watchdog_irq_enable | watchdog_reset_enable |
                                 interval_timer_config |
                                 (protector_monitor_mode != 2'b00));
    end
  end

  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_analog_domain_en <= 1'b0;
    end else begin
      o_analog_domain_en <= !quiet_state(next_state);
    end
  end

  // ----------------------------------------
  // Interrupt outputs
  // ----------------------------------------
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_brownout_irq <= 1'b0;
    end else begin
      o_brownout_irq <= events[`EV_BO_RECOVER] & config_reg[`CFG_BO_IRQ_BIT];
    end
  end

  // Includes this cycle's events so the line rises with the flag
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_mask & (irq_status | {4'h0, events}));
    end
  end

endmodule

/* test/power_state_sequencer_checker.sv */
// Purpose: Port assertions for the power state sequencer
// Assumes: Bench sets the recovery window to 8 cycles
// Notes:   Window sequence is unrolled for that value
`timescale 1ns/1ns
module power_state_sequencer_checker #(
  parameter BO_WINDOW_CYCLES = 8
) (
  input wire       i_sys_clk,
  input wire       i_resetn,
  input wire       i_supply_low,
  input wire       i_stop_req,
  input wire       i_adc_active,
  input wire       i_prot_active,
  input wire       i_interval_timer_active,
  input wire       i_internal_irq,
  input wire       i_ext_irq,
  input wire       i_twowire_irq,
  input wire       i_port0_wake,
  input wire       i_port1_wake,
  input wire       i_charger_sense_input,
  input wire       o_cpu_run,
  input wire       o_ip_hold,
  input wire       o_instruction_oscillator_en,
  input wire       o_analog_oscillator_en,
  input wire       o_analog_domain_en,
  input wire [4:0] o_state
);
  wire bo  = o_state == 5'h01;
  wire cpu = o_state == 5'h02;
  wire ana = o_state == 5'h04;
  wire slp = o_state == 5'h08;
  wire wk  = i_twowire_irq | i_port0_wake | i_port1_wake | i_charger_sense_input;
  wire act = i_adc_active | i_prot_active | i_interval_timer_active;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // ----------------------------------------
  // Transitions
  // ----------------------------------------
  sequence s_fault;
    (cpu || ana) && i_supply_low ##1 bo;
  endsequence
  a_window_wait: assert property (s_fault ##1 (i_supply_low && bo)[*7]
    |-> ##[0:2] o_state == 5'h10)
    else $error("no wait state");
  a_low_brownout: assert property ((cpu || ana) && i_supply_low |=> bo)
    else $error("no brownout");
  a_good_cpu: assert property (bo && !i_supply_low |=> cpu)
    else $error("no cpu entry");
  a_stop_analog: assert property (cpu && i_stop_req && act && !i_supply_low |=> ana)
    else $error("no analog");
  a_analog_wake: assert property (ana && !i_supply_low && (i_ext_irq | i_internal_irq) |=> cpu)
    else $error("no analog wake");
  a_sleep_wake: assert property (slp && wk |=> bo)
    else $error("no sleep wake");
  a_sleep_hold: assert property (slp && !wk |=> slp)
    else $error("sleep left");
  // Why: halting without a held pointer would lose the resume point
  a_halt_outputs: assert property (o_ip_hold == bo && o_cpu_run == cpu)
    else $error("halt outputs");
  a_sleep_quiet: assert property (slp |-> !(o_cpu_run |
    o_instruction_oscillator_en | o_analog_oscillator_en | o_analog_domain_en))
    else $error("sleep not quiet");
endmodule
bind power_state_sequencer power_state_sequencer_checker
  #(.BO_WINDOW_CYCLES(BO_WINDOW_CYCLES)) u_chk (.*);

/* test/power_env_model.sv */
// Purpose: Supply comparator and charger sense
// Assumes: Bench commands; one clock of comparator delay
// Notes:   Supply reads low from reset until the first clock edge after release
`timescale 1ns/1ns
module power_env_model (
  input  wire i_sys_clk,
  input  wire i_resetn,
  input  wire i_droop,
  input  wire i_plug,
  output reg  o_supply_low,
  output reg  o_charger_sense
);
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_supply_low    <= 1'b1;
      o_charger_sense <= 1'b0;
    end else begin
      o_supply_low    <= i_droop;
      o_charger_sense <= i_plug;
    end
  end
endmodule

/* test/tb_power_state_sequencer.sv */
// Purpose: Self-checking bench for the power state sequencer
// Assumes: Window shortened to 8 cycles
// Notes:   Wake sources chosen at random from a fixed seed
`timescale 1ns/1ns
`include "power_state_sequencer_consts.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_power_state_sequencer;
  logic       i_sys_clk, i_resetn, i_wr, i_rd, i_stop_req, droop, plug, seen_bo;
  logic       i_adc_active, i_prot_active, i_interval_timer_active, i_internal_irq;
  logic       i_ext_irq, i_twowire_irq, i_port0_wake, i_port1_wake;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, d, r;
  wire        i_supply_low, i_charger_sense_input, o_cpu_run, o_ip_hold, o_irq;
  wire        o_instruction_oscillator_en, o_analog_oscillator_en;
  wire        o_analog_domain_en, o_brownout_irq;
  wire [7:0]  o_rdata;
  wire [4:0]  o_state;
  int         fail_count = 0, checked = 0;
  power_env_model u_power_env_model (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_droop(droop), .i_plug(plug), .o_supply_low(i_supply_low),
    .o_charger_sense(i_charger_sense_input));
  power_state_sequencer #(.BO_WINDOW_CYCLES(8)) u_power_state_sequencer (.*);
  initial begin
    i_sys_clk = 0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) if (o_brownout_irq === 1'b1) seen_bo <= 1'b1;
  // ----------------------------------------
  // Bus and wait tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task automatic wr(input [3:0] a, input [7:0] v);
    i_addr <= a; i_wdata <= v; i_wr <= 1'b1; tick(1); i_wr <= 1'b0; tick(1);
  endtask
  task automatic rd(input [3:0] a, output [7:0] v);
    i_addr <= a; i_rd <= 1'b1; tick(1); i_rd <= 1'b0;
    @(negedge i_sys_clk) v = o_rdata;
    tick(1);
  endtask
  // Bounded poll; sampled mid-cycle so edge updates have landed
  task automatic wait_st(input [4:0] e);
    for (int k = 0; k < 20; k++) begin
      @(negedge i_sys_clk);
      if (o_state === e) break;
    end
    `CHK(o_state, e)
    tick(1);
  endtask
  task automatic bo_blip;
    droop <= 1; wait_st(5'h01); droop <= 0; wait_st(5'h02); @(negedge i_sys_clk);
  endtask
  task automatic complete_run;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000 fail_count++;
    complete_run;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {i_wr, i_rd, i_stop_req, i_adc_active, i_prot_active, i_interval_timer_active} = '0;
    {i_internal_irq, i_ext_irq, i_twowire_irq, i_port0_wake, i_port1_wake, plug} = '0;
    {droop, seen_bo, i_resetn, i_addr, i_wdata} = {1'b1, 14'h0};
    void'($urandom(32'hc78fb0fe));
    tick(5); i_resetn <= 1; tick(3);
    wait_st(5'h01);
    `CHK(o_ip_hold, 1'b1)
    rd(`REG_WD_FLAGS, d); `CHK(d, `RST_WD_FLAGS)
    rd(4'h7, d); `CHK(d, 8'h00)
    droop <= 0; wait_st(5'h02);
    wr(`REG_CONFIG, 8'h08); wr(`REG_IRQ_MASK, 8'h0f);
    for (int n = 0; n < 10; n++) begin
      r = (n == 0) ? 8'h00 : $urandom;
      {i_adc_active, i_prot_active, i_interval_timer_active} <= r[2:0]; tick(1);
      if (r[5]) wr(`REG_CLOCK_STOP, 8'h10);
      else begin i_stop_req <= 1; tick(1); i_stop_req <= 0; end
      if (r[2:0] != 3'h0) begin
        wait_st(5'h04);
        if (r[6]) i_ext_irq <= 1; else i_internal_irq <= 1;
        wait_st(5'h02);
      end else begin
        wait_st(5'h08);
        droop <= 1; tick(4); wait_st(5'h08);
        case (r[4:3])
          2'h0: i_twowire_irq <= 1;
          2'h1: i_port0_wake <= 1;
          2'h2: i_port1_wake <= 1;
          default: plug <= 1;
        endcase
        wait_st(5'h01);
      end
      {i_internal_irq, i_ext_irq, i_twowire_irq, i_port0_wake, i_port1_wake} <= '0;
      {plug, droop, i_adc_active, i_prot_active, i_interval_timer_active} <= '0;
      wait_st(5'h02);
    end
    rd(`REG_IRQ_STATUS, d); seen_bo <= 0; bo_blip;
    `CHK(seen_bo, 1'b1)
    `CHK(o_irq, 1'b1)
    tick(1); rd(`REG_IRQ_STATUS, d); `CHK(d[`EV_BO_RECOVER], 1'b1)
    @(negedge i_sys_clk);
    `CHK(o_irq, 1'b0)
    tick(1); wr(`REG_IRQ_MASK, 8'h00); bo_blip; `CHK(o_irq, 1'b0)
    tick(1); rd(`REG_IRQ_STATUS, d); `CHK(d[`EV_BO_RECOVER], 1'b1)
    droop <= 1; wait_st(5'h10);
    droop <= 0; tick(4); wait_st(5'h10);
    plug <= 1; wait_st(5'h01);
    plug <= 0; wait_st(5'h02);
    wr(`REG_WD_FLAGS, 8'h40); @(negedge i_sys_clk);
    `CHK(o_analog_oscillator_en, 1'b1)
    tick(1); i_stop_req <= 1; tick(1); i_stop_req <= 0;
    wait_st(5'h04);
    complete_run;
  end
endmodule
